// file: shared/nct_pkg.sv
package nct_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned MODE_W = 3;
  localparam int unsigned SB_W = 8;
  localparam int unsigned CHAIN_CNT = 10;
  localparam int unsigned CHAIN_W = 60;
  // chain lengths (pin counts)
  localparam int unsigned LEN_A0 = 53;
  localparam int unsigned LEN_A1 = 53;
  localparam int unsigned LEN_A2 = 53;
  localparam int unsigned LEN_A3 = 53;
  localparam int unsigned LEN_A4 = 12;
  localparam int unsigned LEN_A5 = 16;
  localparam int unsigned LEN_A6 = 28;
  localparam int unsigned LEN_A7 = 26;
  localparam int unsigned LEN_A8 = 36;
  localparam int unsigned LEN_A9 = 36;
  localparam int unsigned LEN_A5_OLD = 17;
  localparam int unsigned LEN_B0 = 8;
  localparam int unsigned RD_CLK_POS = 16;
  // sideband bit order along the second-mode chain
  localparam logic [23:0] B0_ORDER = 24'hF74688;
  localparam logic [2:0] PAT_FIRST = 3'h0;
  localparam logic [2:0] PAT_SECOND = 3'h1;
  localparam logic [1:0] MODE_RST = 2'h0;

  typedef enum logic [1:0] {
    NCT_OFF = 2'h0,
    NCT_FIRST = 2'h1,
    NCT_SECOND = 2'h2
  } nct_mode_t;

  typedef struct packed {
    logic entry_n;
    logic [MODE_W-1:0] pattern_n;
  } nct_entry_t;

  typedef struct packed {
    logic [SB_W-1:0] sb_o;
    logic [SB_W-1:0] sb_oe;
    logic cpu_reset_out_n_n;
    logic cpu_reset_out_n_oe;
  } nct_pins_t;
endpackage : nct_pkg

// file: design/nct_chain.sv
`timescale 1ns/1ps
// one cascaded chain: each stage nands the next pin with the previous
module nct_chain #(
  parameter int unsigned LEN = 8
) (
  input wire logic [nct_pkg::CHAIN_W-1:0] pins_i,
  input wire logic seed_i,
  output logic out_o
);
  logic [LEN:0] stage;
  assign stage[0] = seed_i;
  genvar g;
  generate
    for (g = 0; g < LEN; g++) begin : g_stage
      assign stage[g+1] = ~(stage[g] & pins_i[g]); // [R11]
    end
  endgenerate
  assign out_o = stage[LEN];
endmodule : nct_chain

// file: design/nct_top.sv
`timescale 1ns/1ps
// Operation
// R1 - second mode: eight sideband pins are inputs, result on cpu reset pin
// R2 - first mode: sideband pins drive the eight chain results
// R3 - second chain order is sideband 0,1,2,3,4,6,5,7
// R4 - read clock pad removed from chain A5 seventeenth place
// R5 - tester drops that pad and inverts the sixteen pins after it
// R6 - mobile strap: A5 tested together with A9, one output
// R7 - entry pin low latches pattern; 000 first mode, 001 second
// R8 - tester releases entry pin four write clocks after bus reset
// R9 - tester drives inputs high, then low one by one in order; the test does so for sideband only, chain pins random
// R10 - strap off: A4/A5 idle; on: they feed A8/A9
// R11 - chain outputs are pure cascades, no flops after mode latch
module nct_top (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic test_entry_n_i,
  input wire logic [2:0] mode_pattern_n_i,
  input wire logic mobile_strap_n_i,
  input wire logic [599:0] chain_pins_i,
  input wire logic [7:0] sideband_i,
  output logic [7:0] sideband_o,
  output logic [7:0] sideband_oe_o,
  output logic cpu_reset_out_n_o,
  output logic cpu_reset_out_oe_o,
  output logic [1:0] mode_o
);
  typedef struct packed {
    nct_pkg::nct_entry_t s1;
    nct_pkg::nct_entry_t s2;
    logic strap1;
    logic strap2;
    nct_pkg::nct_mode_t mode;
    logic mobile_mode;
  } nct_state_t;

  nct_state_t st_q, st_d;
  logic [9:0] res;
  logic [59:0] b0_pins;
  logic b0_out;

  function automatic nct_pkg::nct_mode_t decode(input logic [2:0] p);
    case (p)
      nct_pkg::PAT_FIRST: decode = nct_pkg::NCT_FIRST;
      nct_pkg::PAT_SECOND: decode = nct_pkg::NCT_SECOND;
      default: decode = nct_pkg::NCT_OFF;
    endcase
  endfunction : decode

  // entry pin acts as a latch enable; sync first since pins are async
  always_comb begin
    st_d = st_q;
    st_d.s1.entry_n = test_entry_n_i;
    st_d.s1.pattern_n = mode_pattern_n_i;
    st_d.s2 = st_q.s1;
    st_d.strap1 = mobile_strap_n_i;
    st_d.strap2 = st_q.strap1;
    if (!st_q.s2.entry_n) begin
      st_d.mode = decode(st_q.s2.pattern_n); // [R7]
      st_d.mobile_mode = ~st_q.strap2;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  localparam int unsigned LENS [10] = '{nct_pkg::LEN_A0, nct_pkg::LEN_A1,
    nct_pkg::LEN_A2, nct_pkg::LEN_A3, nct_pkg::LEN_A4, nct_pkg::LEN_A5,
    nct_pkg::LEN_A6, nct_pkg::LEN_A7, nct_pkg::LEN_A8, nct_pkg::LEN_A9};

  // A5 has sixteen stages now; the old read clock stage is gone [R4]
  genvar c;
  generate
    for (c = 0; c < 10; c++) begin : g_chain
      logic seed;
      if (c == 8 || c == 9) begin : g_pair
        // strap on: lower chain result feeds the paired chain [R6] [R10]
        assign seed = st_q.mobile_mode ? res[c-4] : 1'b1;
      end else begin : g_plain
        assign seed = 1'b1;
      end
      nct_chain #(.LEN(LENS[c])) u_chain (
        .pins_i(chain_pins_i[c*60 +: 60]),
        .seed_i(seed),
        .out_o(res[c])
      );
    end
  endgenerate

  // second chain fed in the documented sideband order [R3]
  generate
    for (c = 0; c < 8; c++) begin : g_b0
      assign b0_pins[c] = sideband_i[nct_pkg::B0_ORDER[c*3 +: 3]];
    end
  endgenerate
  assign b0_pins[59:8] = '0;

  nct_chain #(.LEN(nct_pkg::LEN_B0)) u_b0 (
    .pins_i(b0_pins),
    .seed_i(1'b1),
    .out_o(b0_out)
  );

  // results are pure cascades; a flop here would hide pin toggles
  // from the tester, so outputs follow combinationally [R11]
  always_comb begin
    sideband_o = '0;
    sideband_oe_o = '0;
    cpu_reset_out_n_o = 1'b1;
    cpu_reset_out_oe_o = 1'b0;
    mode_o = st_q.mode;
    if (st_q.mode == nct_pkg::NCT_FIRST) begin
      sideband_oe_o = 8'hFF; // [R2]
      sideband_o = {res[7], res[6], res[9], res[8], res[3:0]}; // [R2]
    end else if (st_q.mode == nct_pkg::NCT_SECOND) begin
      cpu_reset_out_oe_o = 1'b1; // [R1]
      cpu_reset_out_n_o = b0_out; // [R1]
    end
  end

  // one clock domain, so checks share one clock and one reset
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  a_second_drive: assert property ( // [R1]
    st_q.mode == nct_pkg::NCT_SECOND |-> cpu_reset_out_oe_o
      && sideband_oe_o == 8'h00)
    else $error("second mode pin directions wrong");

  a_b0_result: assert property ( // [R1]
    st_q.mode == nct_pkg::NCT_SECOND |-> cpu_reset_out_n_o == b0_out)
    else $error("second chain result not on reset pin");

  a_cpu_reset_out_n_idle: assert property ( // [R1]
    st_q.mode != nct_pkg::NCT_SECOND |-> cpu_reset_out_n_o
      && !cpu_reset_out_oe_o)
    else $error("reset pin driven outside second mode");

  a_first_drive: assert property ( // [R2]
    st_q.mode == nct_pkg::NCT_FIRST |-> sideband_oe_o == 8'hFF
      && !cpu_reset_out_oe_o)
    else $error("first mode sideband not driven");

  a_off_quiet: assert property ( // [R2]
    st_q.mode == nct_pkg::NCT_OFF |-> sideband_oe_o == 8'h00
      && sideband_o == 8'h00)
    else $error("sideband driven with no mode");

  a_b0_order: assert property ( // [R3]
    b0_pins[5] == sideband_i[6] && b0_pins[6] == sideband_i[5])
    else $error("second chain order wrong");

  a_b0_ends: assert property ( // [R3]
    b0_pins[4:0] == sideband_i[4:0] && b0_pins[7] == sideband_i[7])
    else $error("second chain straight bits wrong");

  a_mode_latch: assert property ( // [R7]
    !st_q.s2.entry_n && st_q.s2.pattern_n == 3'h1
      |=> mode_o == 2'h2)
    else $error("mode pattern not latched");

  a_first_latch: assert property ( // [R7]
    !st_q.s2.entry_n && st_q.s2.pattern_n == 3'h0
      |=> mode_o == 2'h1)
    else $error("first mode pattern not latched");

  a_bad_pattern: assert property ( // [R7]
    !st_q.s2.entry_n && st_q.s2.pattern_n > 3'h1
      |=> mode_o == 2'h0)
    else $error("unknown pattern selected a mode");

  a_mode_hold: assert property ( // [R7]
    st_q.s2.entry_n |=> $stable(mode_o))
    else $error("mode changed while entry released");

  a_strap_latch: assert property ( // [R6]
    !st_q.s2.entry_n |=> st_q.mobile_mode == !$past(st_q.strap2))
    else $error("mobile strap not latched with mode");

  a_pair_off: assert property ( // [R10]
    !st_q.mobile_mode |-> g_chain[9].seed)
    else $error("paired chain not isolated");

  a_pair8_off: assert property ( // [R10]
    !st_q.mobile_mode |-> g_chain[8].seed)
    else $error("chain A8 not isolated");

  a_pair8_on: assert property ( // [R10]
    st_q.mobile_mode |-> g_chain[8].seed == res[4])
    else $error("A4 not feeding A8");

  a_sb_pairing: assert property ( // [R10]
    st_q.mode == nct_pkg::NCT_FIRST |-> sideband_o[4] == res[8]
      && sideband_o[5] == res[9])
    else $error("paired chain results misplaced");

  a_pair_on: assert property ( // [R6]
    st_q.mobile_mode |-> g_chain[9].seed == res[5])
    else $error("A5 not feeding A9");

  // last stage must be a nand of the final pin, no flop in the path
  a_cascade: assert property ( // [R11]
    st_q.mode == nct_pkg::NCT_FIRST |-> sideband_o[0]
      == ~(g_chain[0].u_chain.stage[52] & chain_pins_i[52]))
    else $error("chain output not combinational");

  c_first: cover property (mode_o == 2'h1);
  c_second: cover property (mode_o == 2'h2);
  c_mobile: cover property (
    st_q.mobile_mode && mode_o == 2'h1);
  c_entry: cover property (!st_q.s2.entry_n);
  c_bad: cover property (!st_q.s2.entry_n && st_q.s2.pattern_n > 3'h1);
endmodule : nct_top

// file: tb/nct_tester.sv
`timescale 1ns/1ps
// board tester: entry held low through reset, released late
module nct_tester (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [2:0] pat_i,
  output logic entry_n_o = 1'b0,
  output logic [2:0] pattern_n_o
);
  int cnt = 4;
  // pattern held steady, the sync chain may still sample it
  assign pattern_n_o = pat_i;
  always @(posedge clk_i) begin
    if (rst_i || go_i) begin
      entry_n_o <= 1'b0;
      cnt <= 4;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else begin
      entry_n_o <= 1'b1;
    end
  end
endmodule : nct_tester

// file: tb/test_nct_top.sv
`timescale 1ns/1ps
module test_nct_top;
  logic clk = 0, rst = 1, go = 0, strap_n = 1, entry_n, crst_n, crst_oe;
  logic [2:0] pat = 3'h7, pat_n;
  logic [599:0] pins = '0;
  logic [7:0] sb = 8'hFF, sb_o, sb_oe;
  logic [1:0] mode;
  int fail_count = 0, n_compared = 0;
  int len [10] = '{53, 53, 53, 53, 12, 16, 28, 26, 36, 36};
  int ord [8] = '{0, 1, 2, 3, 4, 6, 5, 7};
  always #2 clk = ~clk;
  nct_top nct_top_inst (.core_clk_i(clk), .rst_i(rst),
    .test_entry_n_i(entry_n), .mode_pattern_n_i(pat_n),
    .mobile_strap_n_i(strap_n), .chain_pins_i(pins), .sideband_i(sb),
    .sideband_o(sb_o), .sideband_oe_o(sb_oe), .cpu_reset_out_n_o(crst_n),
    .cpu_reset_out_oe_o(crst_oe), .mode_o(mode));
  nct_tester nct_tester_inst (.clk_i(clk), .rst_i(rst), .go_i(go),
    .pat_i(pat), .entry_n_o(entry_n), .pattern_n_o(pat_n));
  function automatic logic cas(int c, logic s);
    logic v;
    v = s;
    for (int k = 0; k < len[c]; k++) v = ~(v & pins[c*60+k]);
    return v;
  endfunction : cas
  function automatic logic bcas();
    logic v;
    v = 1'b1;
    for (int j = 0; j < 8; j++) v = ~(v & sb[ord[j]]);
    return v;
  endfunction : bcas
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run();
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic enter(logic [2:0] p, logic s);
    int i;
    @(negedge clk);
    pat = p;
    strap_n = s;
    go = 1;
    @(negedge clk);
    go = 0;
    i = 0;
    while (entry_n !== 1'b1 && i < 20) begin
      @(negedge clk);
      i++;
    end
    if (i == 20) begin
      fail_count++;
      complete_run();
    end
    chk({6'h0, mode}, p == 3'h0 ? 8'h1 : (p == 3'h1 ? 8'h2 : 8'h0));
  endtask : enter
  initial begin
    void'($urandom(16));
    repeat (8) @(negedge clk);
    rst = 0;
    // unknown pattern must leave the pins undriven
    enter(3'h5, 1'b1);
    chk({sb_oe[6:0], crst_oe}, 8'h0);
    for (int m = 0; m < 2; m++) begin
      enter(3'h0, m[0]);
      repeat (16) begin
        @(negedge clk);
        for (int b = 0; b < 600; b++) pins[b] = 1'($urandom);
        #1;
        chk(sb_oe, 8'hFF);
        chk(sb_o, {cas(7, 1'b1), cas(6, 1'b1),
          cas(9, m ? 1'b1 : cas(5, 1'b1)), cas(8, m ? 1'b1 : cas(4, 1'b1)),
          cas(3, 1'b1), cas(2, 1'b1), cas(1, 1'b1), cas(0, 1'b1)});
        // old test: pad high as 17th stage, then invert what follows
        if (m == 0) chk({7'h0, sb_o[5]},
          {7'h0, cas(9, ~(~(cas(5, 1'b1) & 1'b1)))});
      end
    end
    enter(3'h1, 1'b1);
    chk({sb_oe[6:0], crst_oe}, 8'h1);
    for (int k = 0; k <= 8; k++) begin
      @(negedge clk);
      if (k == 0) sb = 8'hFF;
      else sb[ord[k-1]] = 1'b0;
      #1;
      chk({7'h0, crst_n}, {7'h0, bcas()});
    end
    complete_run();
  end
endmodule : test_nct_top
